// *** src/cfs_fault_supervisor.sv ***
// Fault and warning supervisor with register port and power stage controls.
// Assumes measurement flags arrive on core_clk; stop and bias inputs are pins.
`timescale 1ns/1ps
module cfs_fault_supervisor #(
  parameter int unsigned MS_CYCLES = cfs_pkg::MS_CYCLES_DEF,
  parameter int unsigned OC_GF_CYCLES = cfs_pkg::OC_GF_CYCLES_DEF,
  parameter int unsigned OVERLOAD_CYCLES = cfs_pkg::OVERLOAD_CYCLES_DEF
) (
  input wire logic core_clk, // 25 MHz clock
  input wire logic rst_n, // Async reset
  input wire logic [15:0] reg_addr, // Register index
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire cfs_pkg::cfs_meas_t meas, // Measurement flags
  input wire logic emergency_stop_input, // High while stop loop driven
  input wire logic bias_on_input, // Bias on/off discrete
  output logic power_stage_en, // Power stage switching enable
  output logic dc_contactor_close, // DC contactor drive
  output logic ac_contactor_close, // AC contactor drive
  output logic fault_out, // Isolated fault output
  output cfs_pkg::cfs_state_t state_out, // Operating state
  output logic [2:0] warn_out // Warning flags
);
  logic emergency_stop_input_meta_reg, emergency_stop_input_sync_reg, bias_meta_reg, bias_sync_reg;
  logic [31:0] ms_cnt_reg, oc_cnt_reg, ol_cnt_reg;
  logic ms_tick_reg;
  logic [15:0] hb_value_reg, hb_ms_reg, hb_timeout_reg, auto_resume_reg, remind_reg;
  logic [15:0] rt_ms_reg, pd_ms_reg, latched_reg, latched_next, cond;
  logic hb_armed_reg;
  logic [3:0] rt_src_reg, cal_cnt_reg;
  logic [7:0] temp_stat_reg;
  cfs_pkg::cfs_cfg_t cfg_reg;
  cfs_pkg::cfs_state_t state_reg, state_next;
  logic wr_hb, wr_clear, clear_cmd, wr_run, run_on, hb_good, hb_expired, rt_expired;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
  endfunction

  assign wr_hb = reg_wr && hit(reg_addr, cfs_pkg::OFF_HEARTBEAT);
  assign wr_clear = reg_wr && hit(reg_addr, cfs_pkg::OFF_FAULT_CLEAR);
  assign clear_cmd = wr_clear && reg_wdata[cfs_pkg::CMD_BIT];
  assign wr_run = reg_wr && hit(reg_addr, cfs_pkg::OFF_RUN_CMD);
  assign run_on = wr_run && reg_wdata[cfs_pkg::CMD_BIT];

  // Pin synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      emergency_stop_input_meta_reg <= 1'b0;
      emergency_stop_input_sync_reg <= 1'b0;
      bias_meta_reg <= 1'b0;
      bias_sync_reg <= 1'b0;
    end else begin
      emergency_stop_input_meta_reg <= emergency_stop_input;
      emergency_stop_input_sync_reg <= emergency_stop_input_meta_reg;
      bias_meta_reg <= bias_on_input;
      bias_sync_reg <= bias_meta_reg;
    end
  end

  // Millisecond tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_reg <= 32'h0000_0000;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= (ms_cnt_reg == MS_CYCLES - 1);
      ms_cnt_reg <= (ms_cnt_reg == MS_CYCLES - 1) ? 32'h0000_0000 : ms_cnt_reg + 32'h0000_0001;
    end
  end

  // Software-written settings
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_timeout_reg <= cfs_pkg::HB_TIMEOUT_RST;
      auto_resume_reg <= cfs_pkg::AUTO_RESUME_RST;
      remind_reg <= cfs_pkg::FILTER_REMIND_RST;
      cfg_reg <= cfs_pkg::CONFIG_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, cfs_pkg::OFF_HB_TIMEOUT)) hb_timeout_reg <= reg_wdata;
      if (hit(reg_addr, cfs_pkg::OFF_AUTO_RESUME)) auto_resume_reg <= reg_wdata;
      if (hit(reg_addr, cfs_pkg::OFF_FILTER_REMIND)) remind_reg <= reg_wdata;
      if (hit(reg_addr, cfs_pkg::OFF_CONFIG)) cfg_reg <= reg_wdata[7:0];
    end
  end

  // Heartbeat watchdog
  assign hb_good = !hb_armed_reg || reg_wdata == 16'h0000 || reg_wdata == 16'(hb_value_reg + 16'h0001);
  assign hb_expired = hb_armed_reg && hb_timeout_reg != 16'h0000 && hb_ms_reg >= hb_timeout_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_value_reg <= 16'h0000;
      hb_armed_reg <= 1'b0;
      hb_ms_reg <= 16'h0000;
    end else begin
      if (wr_hb) begin
        hb_value_reg <= reg_wdata;
        hb_armed_reg <= 1'b1;
      end
      if (wr_hb && hb_good) hb_ms_reg <= 16'h0000;
      else if (ms_tick_reg && hb_armed_reg) hb_ms_reg <= sat_inc(hb_ms_reg);
    end
  end

  // Persistence timers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt_reg <= 32'h0000_0000;
      ol_cnt_reg <= 32'h0000_0000;
      pd_ms_reg <= 16'h0000;
    end else begin
      if (|meas.ac_oc_phase && cfg_reg.grid_forming) begin
        if (oc_cnt_reg <= OC_GF_CYCLES) oc_cnt_reg <= oc_cnt_reg + 32'h0000_0001;
      end else begin
        oc_cnt_reg <= 32'h0000_0000;
      end
      if (meas.hw_limit) begin
        if (ol_cnt_reg < OVERLOAD_CYCLES) ol_cnt_reg <= ol_cnt_reg + 32'h0000_0001;
      end else begin
        ol_cnt_reg <= 32'h0000_0000;
      end
      if (bias_sync_reg || !meas.stage_active_fb) pd_ms_reg <= 16'h0000;
      else if (ms_tick_reg) pd_ms_reg <= sat_inc(pd_ms_reg);
    end
  end

  // Ride-through offline timer and source
  assign rt_expired = state_reg == cfs_pkg::ST_OFFLINE && rt_ms_reg >= auto_resume_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_ms_reg <= 16'h0000;
      rt_src_reg <= 4'h0;
    end else if (state_reg == cfs_pkg::ST_RUNNING) begin
      rt_ms_reg <= 16'h0000;
      rt_src_reg <= meas.rt_trip;
    end else if (state_reg == cfs_pkg::ST_OFFLINE && ms_tick_reg) begin
      rt_ms_reg <= sat_inc(rt_ms_reg);
    end
  end

  // Live fault conditions
  always_comb begin
    cond = 16'h0000;
    cond[cfs_pkg::F_AC_OC] = |meas.ac_oc_phase && (!cfg_reg.grid_forming || oc_cnt_reg > OC_GF_CYCLES);
    cond[cfs_pkg::F_AC_OV] = |meas.ac_ov_ll && meas.ac_closed_fb;
    cond[cfs_pkg::F_LOW_VOLTAGE_RIDE_THROUGH +: 4] = rt_expired ? rt_src_reg : 4'h0;
    cond[cfs_pkg::F_ISLAND] = meas.island && cfg_reg.anti_island_en
                              && cfg_reg.island_mode == cfs_pkg::ISLAND_MODE_FAULT;
    cond[cfs_pkg::F_EMERGENCY_STOP_INPUT] = !emergency_stop_input_sync_reg;
    cond[cfs_pkg::F_HEARTBEAT] = hb_expired;
    cond[cfs_pkg::F_POWER_DOWN] = pd_ms_reg >= cfs_pkg::POWER_DOWN_MS;
    cond[cfs_pkg::F_DC_OV] = meas.dc_ov;
    cond[cfs_pkg::F_DC_OC] = meas.dc_oc;
    cond[cfs_pkg::F_DC_UV] = meas.dc_uv;
    cond[cfs_pkg::F_TEMP] = |meas.temp_src;
    cond[cfs_pkg::F_OVERLOAD] = ol_cnt_reg >= OVERLOAD_CYCLES;
  end

  // Clear keeps only bits whose cause persists; new causes always set
  assign latched_next = clear_cmd ? cond : (latched_reg | cond);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_reg <= 16'h0000;
      temp_stat_reg <= 8'h00;
    end else begin
      latched_reg <= latched_next;
      temp_stat_reg <= clear_cmd ? meas.temp_src : (temp_stat_reg | meas.temp_src);
    end
  end

  // Operating state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cfs_pkg::ST_DISABLED: begin
        if (run_on && bias_sync_reg) state_next = cfs_pkg::ST_RUNNING;
      end
      cfs_pkg::ST_RUNNING: begin
        if ((wr_run && !run_on) || !bias_sync_reg) state_next = cfs_pkg::ST_DISABLED;
        else if (!cfg_reg.grid_forming && |meas.rt_trip) state_next = cfs_pkg::ST_OFFLINE;
      end
      cfs_pkg::ST_OFFLINE: begin
        if ((wr_run && !run_on) || !bias_sync_reg) state_next = cfs_pkg::ST_DISABLED;
        else if (meas.grid_ok && !(|meas.rt_trip)) state_next = cfs_pkg::ST_RUNNING;
      end
      cfs_pkg::ST_FAULT: begin
        if (clear_cmd) state_next = cfs_pkg::ST_CALIBRATE;
      end
      cfs_pkg::ST_CALIBRATE: begin
        if (cal_cnt_reg == cfs_pkg::CAL_CYCLES) state_next = cfs_pkg::ST_DISABLED;
      end
      default: state_next = cfs_pkg::ST_FAULT;
    endcase
    if (latched_next != 16'h0000) state_next = cfs_pkg::ST_FAULT;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cfs_pkg::ST_DISABLED;
      cal_cnt_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cal_cnt_reg <= (state_reg == cfs_pkg::ST_CALIBRATE) ? 4'(cal_cnt_reg + 4'h1) : 4'h0;
    end
  end

  // Power stage and contactor drives follow the next state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_stage_en <= 1'b0;
      dc_contactor_close <= 1'b0;
      ac_contactor_close <= 1'b0;
      state_out <= cfs_pkg::ST_DISABLED;
    end else begin
      power_stage_en <= state_next == cfs_pkg::ST_RUNNING;
      ac_contactor_close <= state_next == cfs_pkg::ST_RUNNING;
      dc_contactor_close <= state_next == cfs_pkg::ST_RUNNING || state_next == cfs_pkg::ST_OFFLINE;
      state_out <= state_next;
    end
  end

  // Fault output and warnings
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_out <= 1'b0;
      warn_out <= 3'h0;
    end else begin
      fault_out <= (cfg_reg.fo_en && latched_next != 16'h0000) ^ cfg_reg.fo_invert;
      warn_out[cfs_pkg::W_AP_LIMIT] <= cfg_reg.ap_limit_en && meas.ap_clamped;
      warn_out[cfs_pkg::W_SERVICE] <= remind_reg != 16'h0000 && meas.fan_hours > remind_reg;
      warn_out[cfs_pkg::W_NEG_SEQ] <= cfg_reg.unbalance_en && meas.negseq_clamped;
    end
  end

  // Register readback
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        cfs_pkg::OFF_HEARTBEAT: reg_rdata <= hb_value_reg;
        cfs_pkg::OFF_FAULT_FLAGS: reg_rdata <= latched_reg;
        cfs_pkg::OFF_AUTO_RESUME: reg_rdata <= auto_resume_reg;
        cfs_pkg::OFF_HB_TIMEOUT: reg_rdata <= hb_timeout_reg;
        cfs_pkg::OFF_CONFIG: reg_rdata <= {8'h00, cfg_reg};
        cfs_pkg::OFF_WARNINGS: reg_rdata <= {13'h0000, warn_out};
        cfs_pkg::OFF_STATE: reg_rdata <= {11'h000, state_reg};
        cfs_pkg::OFF_TEMP_STATUS: reg_rdata <= {8'h00, temp_stat_reg};
        cfs_pkg::OFF_FILTER_REMIND: reg_rdata <= remind_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_fault_forces_off: assert property (state_reg == cfs_pkg::ST_FAULT |->
    !power_stage_en && !dc_contactor_close && !ac_contactor_close)
    else $error("Power stage or contactor active in Fault");

  a_turn_on_ignored: assert property (state_reg == cfs_pkg::ST_FAULT && run_on |=>
    state_reg != cfs_pkg::ST_RUNNING && !power_stage_en)
    else $error("Turn-on accepted in Fault");

  a_flags_sticky: assert property (!clear_cmd |=>
    (latched_reg & $past(latched_reg)) == $past(latched_reg))
    else $error("Latched fault bit dropped without clear");

  a_fault_out_level: assert property (cfg_reg.fo_en && !cfg_reg.fo_invert && $stable(cfg_reg) |->
    fault_out == (latched_reg != 16'h0000))
    else $error("Fault output disagrees with latched flags");

  a_fault_holds: assert property (state_reg == cfs_pkg::ST_FAULT && !clear_cmd |=>
    state_reg == cfs_pkg::ST_FAULT)
    else $error("Fault state left without clear");

  a_clear_calibrate: assert property ($rose(state_reg == cfs_pkg::ST_CALIBRATE) |->
    latched_reg == 16'h0000 ##16 state_reg != cfs_pkg::ST_CALIBRATE)
    else $error("Calibrate entered with faults or overstayed");

  a_gt_overcurrent: assert property (!cfg_reg.grid_forming && |meas.ac_oc_phase |=>
    latched_reg[cfs_pkg::F_AC_OC] && state_reg == cfs_pkg::ST_FAULT)
    else $error("Grid-tie overcurrent not latched");

  a_ov_gated: assert property (!(|meas.ac_ov_ll) && !$past(latched_reg[cfs_pkg::F_AC_OV]) |->
    !latched_reg[cfs_pkg::F_AC_OV] || $past(meas.ac_closed_fb))
    else $error("Overvoltage latched with contactor open");

  a_emergency_stop_input_fault: assert property (!emergency_stop_input_sync_reg |=> latched_reg[cfs_pkg::F_EMERGENCY_STOP_INPUT])
    else $error("Emergency stop fault missing");

  a_hb_disarmed: assert property (!hb_armed_reg |-> !hb_expired && hb_ms_reg == 16'h0000)
    else $error("Heartbeat checking active before first write");

  a_hb_repeat: assert property (wr_hb && hb_armed_reg && reg_wdata == hb_value_reg
    && reg_wdata != 16'h0000 && hb_ms_reg != 16'h0000 |=> hb_ms_reg != 16'h0000)
    else $error("Repeated heartbeat restarted the timer");

  a_ap_warning: assert property (cfg_reg.ap_limit_en && meas.ap_clamped |=> warn_out[cfs_pkg::W_AP_LIMIT])
    else $error("Active power limit warning missing");

  a_service_warn: assert property (remind_reg != 16'h0000 && meas.fan_hours > remind_reg |=>
    warn_out[cfs_pkg::W_SERVICE])
    else $error("Service warning missing");

  a_neg_seq_warn: assert property (cfg_reg.unbalance_en && meas.negseq_clamped |=>
    warn_out[cfs_pkg::W_NEG_SEQ])
    else $error("Negative sequence warning missing");

  a_fault_enters_state: assert property (latched_reg != 16'h0000 |-> state_reg == cfs_pkg::ST_FAULT)
    else $error("Latched fault without Fault state");

  a_island_fault: assert property (meas.island && cfg_reg.anti_island_en
    && cfg_reg.island_mode == cfs_pkg::ISLAND_MODE_FAULT |=> latched_reg[cfs_pkg::F_ISLAND])
    else $error("Island fault missing");

  a_hb_timeout_fault: assert property (hb_expired |=> latched_reg[cfs_pkg::F_HEARTBEAT])
    else $error("Heartbeat fault missing after timeout");

  a_dc_faults: assert property ({meas.dc_ov, meas.dc_oc, meas.dc_uv} != 3'h0 |=>
    (latched_reg[cfs_pkg::F_DC_OV] >= $past(meas.dc_ov)) && (latched_reg[cfs_pkg::F_DC_OC] >= $past(meas.dc_oc))
    && (latched_reg[cfs_pkg::F_DC_UV] >= $past(meas.dc_uv)))
    else $error("DC fault bit missing");

  a_temp_fault: assert property (|meas.temp_src |=> latched_reg[cfs_pkg::F_TEMP]
    && (temp_stat_reg & $past(meas.temp_src)) == $past(meas.temp_src))
    else $error("Temperature fault or source missing");

  a_overload_trip: assert property (ol_cnt_reg >= OVERLOAD_CYCLES |=> latched_reg[cfs_pkg::F_OVERLOAD])
    else $error("Overload trip missing");
endmodule

// *** src/cfs_pkg.sv ***
// Constants, types and register map of the converter fault supervisor.
// Assumes a 25 MHz core clock and a plain single-cycle register port.
//
// What this block does
// - Active-power-limit warning while limit enable is 1 and power command is clamped.
// - Service warning once fan hours exceed a nonzero filter reminder duration.
// - Negative-sequence limit warning while unbalance control enable is 1 and clamped.
// - Any fault switches power stage off, opens both contactors, enters Fault.
// - Turn-on commands are ignored while in the Fault state.
// - Each fault latches its own status bit, held after the condition ends.
// - Configurable fault output is active while any latched fault bit is set.
// - Fault state and latched flags hold until a fault clear command is written.
// - Clear attempt: all clear gives Calibrate then Disabled, else remaining bits stay.
// - AC overcurrent faults at once in grid-tie, after over 5 s in grid-forming.
// - AC overvoltage on any line-line voltage, judged only with AC contactor closed.
// - Grid-tie ride-through trip goes offline, resumes on recovery, faults on resume timeout.
// - Island fault when island detected, anti-islanding enabled and mode select is 2.
// - Emergency stop fault whenever the stop input is not actively driven.
// - Heartbeat fault if no plus-1 or zero write within the heartbeat timeout.
// - Repeated nonzero heartbeat value is accepted but does not restart the timer.
// - Heartbeat checking stays disarmed after reset until the first heartbeat write.
// - Power-down fault if the stage stays active after bias input deasserts.
// - Separate faults for DC overvoltage, DC undervoltage and DC overcurrent.
// - Temperature fault on any sensor threshold, source kept in temperature status.
// - Overload trip when hardware current limiting persists about 100 ms.
package cfs_pkg;
  // Register offsets (word indices on the register port)
  localparam logic [15:0] OFF_HEARTBEAT = 16'hA30C;
  localparam logic [15:0] OFF_FAULT_CLEAR = 16'hA30E;
  localparam logic [15:0] OFF_FAULT_FLAGS = 16'hA31E;
  localparam logic [15:0] OFF_AUTO_RESUME = 16'hA361;
  localparam logic [15:0] OFF_HB_TIMEOUT = 16'hA36C;
  localparam logic [15:0] OFF_CONFIG = 16'hA400;
  localparam logic [15:0] OFF_RUN_CMD = 16'hA401;
  localparam logic [15:0] OFF_WARNINGS = 16'hA402;
  localparam logic [15:0] OFF_STATE = 16'hA403;
  localparam logic [15:0] OFF_TEMP_STATUS = 16'hA404;
  localparam logic [15:0] OFF_FILTER_REMIND = 16'hA405;

  // Fault flag bit positions
  localparam int F_AC_OC = 0;
  localparam int F_AC_OV = 1;
  localparam int F_LOW_VOLTAGE_RIDE_THROUGH = 2;
  localparam int F_ISLAND = 6;
  localparam int F_EMERGENCY_STOP_INPUT = 7;
  localparam int F_HEARTBEAT = 8;
  localparam int F_POWER_DOWN = 9;
  localparam int F_DC_OV = 10;
  localparam int F_DC_OC = 11;
  localparam int F_DC_UV = 12;
  localparam int F_TEMP = 13;
  localparam int F_OVERLOAD = 14;

  // Warning bit positions
  localparam int W_AP_LIMIT = 0;
  localparam int W_SERVICE = 1;
  localparam int W_NEG_SEQ = 2;

  // Command bit and mode values
  localparam int CMD_BIT = 0;
  localparam logic [1:0] ISLAND_MODE_FAULT = 2'h2;

  // Reset values
  localparam logic [15:0] HB_TIMEOUT_RST = 16'h03E8;
  localparam logic [15:0] AUTO_RESUME_RST = 16'h7530;
  localparam logic [15:0] FILTER_REMIND_RST = 16'h0FA0;
  localparam logic [7:0] CONFIG_RST = 8'h40;

  // Timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int unsigned OC_GF_TIME_S = 5;
  localparam int unsigned OC_GF_CYCLES_DEF = OC_GF_TIME_S * CLK_HZ;
  localparam int unsigned OVERLOAD_TIME_MS = 100;
  localparam int unsigned OVERLOAD_CYCLES_DEF = OVERLOAD_TIME_MS * (CLK_HZ / 1000);
  localparam logic [15:0] POWER_DOWN_MS = 16'h01F4;
  localparam logic [3:0] CAL_CYCLES = 4'hF;

  typedef enum logic [4:0] {
    ST_DISABLED = 5'h01,
    ST_RUNNING = 5'h02,
    ST_OFFLINE = 5'h04,
    ST_FAULT = 5'h08,
    ST_CALIBRATE = 5'h10
  } cfs_state_t;

  typedef struct packed {
    logic fo_invert;
    logic fo_en;
    logic [1:0] island_mode;
    logic anti_island_en;
    logic unbalance_en;
    logic ap_limit_en;
    logic grid_forming;
  } cfs_cfg_t;

  typedef struct packed {
    logic [2:0] ac_oc_phase;
    logic [2:0] ac_ov_ll;
    logic dc_ov;
    logic dc_uv;
    logic dc_oc;
    logic [7:0] temp_src;
    logic hw_limit;
    logic island;
    logic ap_clamped;
    logic negseq_clamped;
    logic [3:0] rt_trip;
    logic grid_ok;
    logic ac_closed_fb;
    logic stage_active_fb;
    logic [15:0] fan_hours;
  } cfs_meas_t;
endpackage

// *** tb/cfs_ctl_model.sv ***
// Behavioural system controller: master of the register port and heartbeat writer.
// Assumes its tasks are called from one bench process, one access at a time.
`timescale 1ns/1ps
module cfs_ctl_model (
  input wire logic core_clk, // Core clock
  output logic [15:0] reg_addr, // Register index
  output logic [15:0] reg_wdata, // Write data
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  input wire logic [15:0] reg_rdata // Read data
);
  logic [15:0] hb_val;

  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hb_val = 16'h0000;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Released lines show no stale value
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  // Heartbeat sequence: previous plus one, or zero to restart
  task automatic hb_next();
    hb_val = hb_val + 16'h0001;
    wr(cfs_pkg::OFF_HEARTBEAT, hb_val);
  endtask

  task automatic hb_zero();
    hb_val = 16'h0000;
    wr(cfs_pkg::OFF_HEARTBEAT, hb_val);
  endtask

  // Retry of a write that seemed lost
  task automatic hb_same();
    wr(cfs_pkg::OFF_HEARTBEAT, hb_val);
  endtask
endmodule

// *** tb/converter_fault_supervisor_tb.sv ***
// Self-checking bench for the fault supervisor, table of fault and warning cases.
// Assumes the controller model in cfs_ctl_model.sv and shortened timing parameters.
`timescale 1ns/1ps
module converter_fault_supervisor_tb;
  typedef struct {
    cfs_pkg::cfs_meas_t m;
    logic [7:0] cfg;
    int hold;
    logic [15:0] fl;
    logic [2:0] wn;
    logic es;
    logic bi;
  } cfs_row_t;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, emergency_stop_input, bias_on_input;
  logic power_stage_en, dc_contactor_close, ac_contactor_close, fault_out;
  logic [2:0] warn_out;
  cfs_pkg::cfs_meas_t meas, idle_m;
  cfs_pkg::cfs_state_t state_out;
  cfs_row_t rows[22];
  logic [15:0] raddr[6] = '{16'hA36C, 16'hA361, 16'hA30E, 16'hA405, 16'hA400, 16'h1234};
  logic [15:0] rexp[6] = '{16'h03E8, 16'h7530, 16'h0000, 16'h0FA0, 16'h0040, 16'h0000};
  int fail_count = 0;
  int cmp_count = 0;

  always #20 core_clk = ~core_clk;

  cfs_ctl_model ctl_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  cfs_fault_supervisor #(.MS_CYCLES(4), .OC_GF_CYCLES(20), .OVERLOAD_CYCLES(10)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas), .emergency_stop_input(emergency_stop_input),
    .bias_on_input(bias_on_input), .power_stage_en(power_stage_en), .dc_contactor_close(dc_contactor_close),
    .ac_contactor_close(ac_contactor_close), .fault_out(fault_out), .state_out(state_out), .warn_out(warn_out));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] v;
    ctl_u.rd(a, v);
    chk(v, exp);
  endtask

  task automatic settle_clear();
    ctl_u.wr(cfs_pkg::OFF_RUN_CMD, 16'h0000);
    ctl_u.wr(cfs_pkg::OFF_FAULT_CLEAR, 16'h0001);
    cyc(20);
  endtask

  function automatic cfs_row_t mk(cfs_pkg::cfs_meas_t m, logic [7:0] cfg, int hold, logic [15:0] fl,
    logic [2:0] wn, logic es = 1'b1, logic bi = 1'b1);
    mk = '{m, cfg, hold, fl, wn, es, bi};
  endfunction

  task automatic run_row(input cfs_row_t r);
    cfs_pkg::cfs_meas_t mm;
    logic flt;
    mm = r.m;
    mm.grid_ok = (r.m.rt_trip == 4'h0);
    flt = (r.fl != 16'h0000);
    ctl_u.wr(cfs_pkg::OFF_CONFIG, {8'h00, r.cfg});
    ctl_u.wr(cfs_pkg::OFF_RUN_CMD, 16'h0001);
    cyc(2);
    #1 chk({11'h000, state_out}, 16'h0002);
    @(posedge core_clk);
    meas <= mm;
    emergency_stop_input <= r.es;
    bias_on_input <= r.bi;
    cyc(r.hold);
    #1 chk({13'h0000, warn_out}, {13'h0000, r.wn});
    @(posedge core_clk);
    meas <= idle_m;
    emergency_stop_input <= 1'b1;
    bias_on_input <= 1'b1;
    cyc(6);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, r.fl);
    #1 chk({11'h000, state_out}, flt ? 16'h0008 : 16'h0002);
    chk({13'h0000, power_stage_en, dc_contactor_close, ac_contactor_close}, flt ? 16'h0000 : 16'h0007);
    chk({15'h0000, fault_out}, {15'h0000, flt});
    ctl_u.wr(cfs_pkg::OFF_RUN_CMD, 16'h0001);
    cyc(2);
    #1 chk({11'h000, state_out}, flt ? 16'h0008 : 16'h0002);
    settle_clear();
    #1 chk({11'h000, state_out}, 16'h0001);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0000);
  endtask

  initial begin
    idle_m = '0;
    idle_m.grid_ok = 1'b1;
    meas = idle_m;
    emergency_stop_input = 1'b1;
    bias_on_input = 1'b1;
    rows[0] = mk('{ac_oc_phase: 3'h1, default: '0}, 8'h40, 2, 16'h0001, 3'h0);
    rows[1] = mk('{ac_oc_phase: 3'h4, default: '0}, 8'h41, 12, 16'h0000, 3'h0);
    rows[2] = mk('{ac_oc_phase: 3'h2, default: '0}, 8'h41, 25, 16'h0001, 3'h0);
    rows[3] = mk('{ac_ov_ll: 3'h1, ac_closed_fb: 1'b1, default: '0}, 8'h40, 2, 16'h0002, 3'h0);
    rows[4] = mk('{ac_ov_ll: 3'h4, default: '0}, 8'h40, 2, 16'h0000, 3'h0);
    rows[5] = mk('{rt_trip: 4'h1, default: '0}, 8'h40, 3, 16'h0000, 3'h0);
    rows[6] = mk('{rt_trip: 4'h2, default: '0}, 8'h40, 30, 16'h0008, 3'h0);
    rows[7] = mk('{island: 1'b1, default: '0}, 8'h68, 2, 16'h0040, 3'h0);
    rows[8] = mk('{island: 1'b1, default: '0}, 8'h58, 2, 16'h0000, 3'h0);
    rows[9] = mk('{default: '0}, 8'h40, 2, 16'h0080, 3'h0, 1'b0);
    rows[10] = mk('{dc_ov: 1'b1, default: '0}, 8'h40, 2, 16'h0400, 3'h0);
    rows[11] = mk('{dc_oc: 1'b1, default: '0}, 8'h40, 2, 16'h0800, 3'h0);
    rows[12] = mk('{dc_uv: 1'b1, default: '0}, 8'h40, 2, 16'h1000, 3'h0);
    rows[13] = mk('{temp_src: 8'h10, default: '0}, 8'h40, 2, 16'h2000, 3'h0);
    rows[14] = mk('{hw_limit: 1'b1, default: '0}, 8'h40, 12, 16'h4000, 3'h0);
    rows[15] = mk('{hw_limit: 1'b1, default: '0}, 8'h40, 8, 16'h0000, 3'h0);
    rows[16] = mk('{ap_clamped: 1'b1, default: '0}, 8'h42, 2, 16'h0000, 3'h1);
    rows[17] = mk('{ap_clamped: 1'b1, default: '0}, 8'h40, 2, 16'h0000, 3'h0);
    rows[18] = mk('{negseq_clamped: 1'b1, default: '0}, 8'h44, 2, 16'h0000, 3'h4);
    rows[19] = mk('{fan_hours: 16'h0FA1, default: '0}, 8'h40, 2, 16'h0000, 3'h2);
    rows[20] = mk('{fan_hours: 16'h0FA0, default: '0}, 8'h40, 2, 16'h0000, 3'h0);
    rows[21] = mk('{stage_active_fb: 1'b1, default: '0}, 8'h40, 2010, 16'h0200, 3'h0, 1'b1, 1'b0);
    cyc(5);
    rst_n <= 1'b1;
    cyc(2);
    for (int i = 0; i < 6; i++) rdchk(raddr[i], rexp[i]);
    ctl_u.wr(cfs_pkg::OFF_FAULT_FLAGS, 16'hFFFF);
    settle_clear();
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0000);
    ctl_u.wr(cfs_pkg::OFF_AUTO_RESUME, 16'h0002);
    foreach (rows[i]) run_row(rows[i]);
    // Temperature sources kept after the condition ends
    @(posedge core_clk);
    meas.temp_src <= 8'h21;
    cyc(2);
    meas.temp_src <= 8'h00;
    cyc(2);
    rdchk(cfs_pkg::OFF_TEMP_STATUS, 16'h0021);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h2000);
    settle_clear();
    rdchk(cfs_pkg::OFF_TEMP_STATUS, 16'h0000);
    // Clear attempt while the stop loop is still open
    @(posedge core_clk);
    emergency_stop_input <= 1'b0;
    cyc(6);
    ctl_u.wr(cfs_pkg::OFF_FAULT_CLEAR, 16'h0001);
    cyc(4);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0080);
    #1 chk({11'h000, state_out}, 16'h0008);
    @(posedge core_clk);
    emergency_stop_input <= 1'b1;
    cyc(6);
    settle_clear();
    #1 chk({11'h000, state_out}, 16'h0001);
    // Heartbeat supervision
    ctl_u.wr(cfs_pkg::OFF_HB_TIMEOUT, 16'h0003);
    cyc(40);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0000);
    ctl_u.hb_zero();
    repeat (4) begin
      cyc(6);
      ctl_u.hb_next();
    end
    rdchk(cfs_pkg::OFF_HEARTBEAT, 16'h0004);
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0000);
    repeat (4) begin
      cyc(6);
      ctl_u.hb_same();
    end
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0100);
    ctl_u.wr(cfs_pkg::OFF_HB_TIMEOUT, 16'h0000);
    settle_clear();
    rdchk(cfs_pkg::OFF_FAULT_FLAGS, 16'h0000);
    complete_run();
  end

  initial begin
    cyc(20000);
    fail_count++;
    complete_run();
  end
endmodule
